// file: rtl/rfm_pkg.sv
// Purpose: shared constants, types and helpers for the fault manager
// Assumes: 25 MHz system clock, 500 kHz sync line
// Notes: voltages in mV, temperature in degrees C
`default_nettype none
package rfm_pkg;
  localparam int CLK_HZ = 25_000_000;
  localparam int SYNC_HZ = 500_000;
  localparam int SYNC_HALF = CLK_HZ / (2 * SYNC_HZ);
  localparam int RESTART_MS = 130;
  localparam int RESTART_CYC = (CLK_HZ / 1000) * RESTART_MS;
  localparam int TMR_W = 22;
  localparam int OT_LIMIT_C = 130;
  localparam int OV_PCT_MIN = 110;
  localparam int OV_PCT_MAX = 130;
  localparam int OV_FLOOR_MV = 500;
  localparam int OV_MARGIN_MV = 250;
  localparam int MV_W = 13;
  // protection_flags bit positions
  localparam int FLG_OV = 0;
  localparam int FLG_UV = 1;
  localparam int FLG_OT = 2;
  localparam int FLG_OC = 3;
  localparam int NFLG = 4;
  localparam logic [NFLG-1:0] FLAGS_RST = 4'hf;
  // manager register map (byte addresses) and control fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam int C_MON = 0;
  localparam int C_RELAY = 1;
  localparam int C_FE = 2;
  localparam int C_CROW = 3;
  localparam int S_FLT = 4;
  localparam int S_SEV = 5;
  localparam int S_FE = 7;
  localparam int S_CROW = 8;

  typedef enum logic [1:0] {
    SEV_SEQ = 2'b00, SEV_CRIT = 2'b01, SEV_EMERG = 2'b11
  } rfm_sev_e;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001, ST_RUN = 5'b00010, ST_TRIP = 5'b00100,
    ST_REMOTE = 5'b01000, ST_SPARE = 5'b10000
  } rfm_state_e;

  // unknown code 2'b10 is taken as critical
  function automatic rfm_sev_e dec_sev(input logic [1:0] c);
    dec_sev = (c == 2'b10) ? SEV_CRIT : rfm_sev_e'(c);
  endfunction : dec_sev

  function automatic logic [MV_W-1:0] ov_limit(
    input logic [MV_W-1:0] sp, input logic [7:0] pct);
    logic [7:0] p;
    logic [MV_W+7:0] prod;
    logic [MV_W-1:0] lim;
    p = pct;
    if (p < 8'(OV_PCT_MIN)) p = 8'(OV_PCT_MIN);
    if (p > 8'(OV_PCT_MAX)) p = 8'(OV_PCT_MAX);
    prod = sp * p;
    lim = MV_W'(prod / (MV_W+8)'(100));
    if (lim < MV_W'(OV_FLOOR_MV)) lim = MV_W'(OV_FLOOR_MV);
    if (lim < MV_W'(sp + MV_W'(OV_MARGIN_MV)))
      lim = MV_W'(sp + MV_W'(OV_MARGIN_MV));
    ov_limit = lim;
  endfunction : ov_limit
endpackage : rfm_pkg
`default_nettype wire

// file: rtl/rfm_link_if.sv
// Purpose: shared fault line, sync line and status path
// Assumes: fault line open drain with pull-up, oe low while driving
// Notes: the wire level is resolved here from every driver
`default_nettype none
interface rfm_link_if;
  logic sync_line;
  logic dev_fault_o;
  logic dev_fault_oe_n;
  logic mgr_fault_o;
  logic mgr_fault_oe_n;
  logic fault_line;
  logic [3:0] flags;
  assign fault_line = !((!dev_fault_oe_n && !dev_fault_o) ||
                        (!mgr_fault_oe_n && !mgr_fault_o));
  modport dev(input sync_line, input fault_line, output dev_fault_o,
              output dev_fault_oe_n, output flags);
  modport mgr(output sync_line, input fault_line, output mgr_fault_o,
              output mgr_fault_oe_n, input flags);
endinterface : rfm_link_if
`default_nettype wire

// file: rtl/rfm_line_codec.sv
// Purpose: sends and decodes turn-off severity on the fault line
// Assumes: line changes at sync falling edges, sampled at rising edges
// Notes: pattern L, bit0, bit1, then low while the request stands
`default_nettype none
module rfm_line_codec (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sync_in,
  input wire logic line_in,
  input wire logic tx_req,
  input wire logic [1:0] tx_sev,
  output logic sync_fall,
  output logic rx_valid,
  output logic rx_active,
  output logic [1:0] rx_sev,
  output logic tx_drive_n
);
  logic s1_q, s2_q, s3_q, l1_q, l2_q, b0_q, sync_rise;
  logic [1:0] ph_q, rx_q;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      l1_q <= 1'b1;
      l2_q <= 1'b1;
    end else begin
      s1_q <= sync_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      l1_q <= line_in;
      l2_q <= l1_q;
    end
  end
  assign sync_fall = s3_q & ~s2_q;
  assign sync_rise = ~s3_q & s2_q;

  // transmit: release at once when the request drops
  always_ff @(posedge clk) begin
    if (sys_rst || !tx_req) begin
      ph_q <= 2'd0;
      tx_drive_n <= 1'b1;
    end else if (sync_fall) begin
      case (ph_q)
        2'd0: begin tx_drive_n <= 1'b0; ph_q <= 2'd1; end // R11 R23
        2'd1: begin tx_drive_n <= tx_sev[0]; ph_q <= 2'd2; end // R11
        2'd2: begin tx_drive_n <= tx_sev[1]; ph_q <= 2'd3; end // R11
        default: tx_drive_n <= 1'b0; // R23
      endcase
    end
  end

  // receive: start low, then two code samples, then hold while low
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_q <= 2'd0;
      b0_q <= 1'b0;
      rx_sev <= 2'b00;
      rx_valid <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (sync_rise) begin
        case (rx_q)
          2'd0: if (!l2_q) rx_q <= 2'd1;
          2'd1: begin b0_q <= l2_q; rx_q <= 2'd2; end // R12
          2'd2: begin // R12
            rx_sev <= {l2_q, b0_q};
            rx_valid <= 1'b1;
            rx_q <= 2'd3;
          end
          default: if (l2_q) rx_q <= 2'd0;
        endcase
      end
    end
  end
  assign rx_active = (rx_q == 2'd3);
endmodule : rfm_line_codec
`default_nettype wire

// file: rtl/rfm_regulator.sv
// Purpose: protection and fault management of one load regulator
// Assumes: detector inputs and config come from the same clock domain
// Notes: fault line and sync line are sampled through the codec
//
// Overview of operation
// R01: overvoltage above pre-bias trips, clears its flag
// R02: overvoltage: high side off, low side on; low side stays on only when style_ov is emergency, critical turns both off
// R03: ov limit 110-130%, min 0.5 V, +0.25 V
// R04: latching and propagation chosen per protection
// R05: non-latching restarts every 130 ms
// R06: latching stays off until cleared or recycled
// R07: sequenced, critical or emergency turn-off styles
// R08: protection state held in protection_flags
// R09: propagating fault pulls fault line low
// R10: line pulled low by other turns off alike
// R11: severity encoded in the falling fault line
// R12: severity recovered by sampling at sync edges
// R13: group formed by shared manager fault input
// R14: manager relays fault with unchanged severity
// R15: propagation options held in spread_config
// R16: manager may cut front end, fire crowbar
// R17: 130 ms interval ignores turn-off delay
// R18: undervoltage uses sequenced turn-off; style_uv set to critical gives a critical turn-off instead
// R19: non-propagating fault leaves fault line released
// R20: overcurrent after pre-bias, critical, always armed
// R21: sync line falling edge is timing reference
// R22: temperature above 130 C trips thermal fault
// R23: severity waveform defined by this design
// R24: flags active low, zero once tripped
`default_nettype none
module rfm_regulator #(
  parameter int RESTART_CYC = rfm_pkg::RESTART_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  rfm_link_if.dev link,
  input wire logic turn_on,
  input wire logic above_prebias,
  input wire logic steady_state,
  input wire logic oc_in,
  input wire logic uv_in,
  input wire logic [rfm_pkg::MV_W-1:0] vout_mv,
  input wire logic [rfm_pkg::MV_W-1:0] setpoint_mv,
  input wire logic [7:0] ov_pct,
  input wire logic [7:0] temp_c,
  input wire logic [3:0] latch_config,
  input wire logic [3:0] spread_config,
  input wire logic [3:0] status_clear,
  input wire logic [1:0] style_ot,
  input wire logic [1:0] style_uv,
  input wire logic [1:0] style_ov,
  output logic hs_en,
  output logic ls_en,
  output logic ls_force,
  output logic ramp_down,
  output logic ramp_up,
  output logic pwm_sync,
  output logic [3:0] protection_flags
);
  localparam logic [rfm_pkg::TMR_W-1:0] TMR_LAST =
    rfm_pkg::TMR_W'(RESTART_CYC - 1);

  rfm_pkg::rfm_state_e st_q;
  rfm_pkg::rfm_sev_e sev_q, sev_d;
  logic [3:0] flags_q, src_q, src_d, cond, ev;
  logic latch_q, prop_q, recyc_q, was_run_q, tmr_done, off;
  logic [rfm_pkg::TMR_W-1:0] tmr_q;
  logic [rfm_pkg::MV_W-1:0] ov_lim;
  logic sync_fall, rx_valid, rx_active, tx_drive_n;
  logic [1:0] rx_sev;
  logic hs_q, ls_q, force_q, rdown_q, rup_q, psync_q;

  rfm_line_codec u_codec (
    .clk(clk),
    .sys_rst(sys_rst),
    .sync_in(link.sync_line),
    .line_in(link.fault_line),
    .tx_req((st_q == rfm_pkg::ST_TRIP) && prop_q),
    .tx_sev(sev_q),
    .sync_fall(sync_fall),
    .rx_valid(rx_valid),
    .rx_active(rx_active),
    .rx_sev(rx_sev),
    .tx_drive_n(tx_drive_n)
  );

  assign link.dev_fault_o = 1'b0;
  assign link.dev_fault_oe_n = tx_drive_n; // R09 R19
  assign link.flags = flags_q; // R08

  assign ov_lim = rfm_pkg::ov_limit(setpoint_mv, ov_pct); // R03

  // live protection conditions
  always_comb begin
    cond = '0;
    cond[rfm_pkg::FLG_OV] = above_prebias && (vout_mv > ov_lim); // R01
    cond[rfm_pkg::FLG_OC] = above_prebias && oc_in; // R20
    cond[rfm_pkg::FLG_UV] = steady_state && uv_in && !oc_in;
    cond[rfm_pkg::FLG_OT] = temp_c > 8'(rfm_pkg::OT_LIMIT_C); // R22
  end
  assign ev = (st_q == rfm_pkg::ST_RUN) ? cond : '0;

  // fixed order OV, OC, OT, UV picks the source when several trip together
  always_comb begin
    src_d = '0;
    sev_d = rfm_pkg::SEV_SEQ;
    if (ev[rfm_pkg::FLG_OV]) begin
      src_d[rfm_pkg::FLG_OV] = 1'b1;
      sev_d = (style_ov == rfm_pkg::SEV_EMERG) ? rfm_pkg::SEV_EMERG
                                               : rfm_pkg::SEV_CRIT; // R07
    end else if (ev[rfm_pkg::FLG_OC]) begin
      src_d[rfm_pkg::FLG_OC] = 1'b1;
      sev_d = rfm_pkg::SEV_CRIT; // R20
    end else if (ev[rfm_pkg::FLG_OT]) begin
      src_d[rfm_pkg::FLG_OT] = 1'b1;
      sev_d = (style_ot == rfm_pkg::SEV_CRIT) ? rfm_pkg::SEV_CRIT
                                              : rfm_pkg::SEV_SEQ; // R07
    end else begin
      src_d[rfm_pkg::FLG_UV] = 1'b1;
      sev_d = (style_uv == rfm_pkg::SEV_CRIT) ? rfm_pkg::SEV_CRIT
                                              : rfm_pkg::SEV_SEQ; // R18
    end
  end

  // active-low flags; a trip in the clear cycle wins
  always_ff @(posedge clk) begin
    if (sys_rst) flags_q <= rfm_pkg::FLAGS_RST;
    else flags_q <= (flags_q | status_clear) & ~ev; // R24 R01 R22
  end

  // restart interval runs from the trip, not from the ramp-down
  always_ff @(posedge clk) begin
    if (sys_rst || st_q != rfm_pkg::ST_TRIP) tmr_q <= '0;
    else if (!tmr_done) tmr_q <= tmr_q + 1'b1; // R17
  end
  assign tmr_done = (tmr_q == TMR_LAST);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= rfm_pkg::ST_IDLE;
      src_q <= '0;
      sev_q <= rfm_pkg::SEV_SEQ;
      latch_q <= 1'b0;
      prop_q <= 1'b0;
      recyc_q <= 1'b0;
    end else begin
      case (st_q)
        rfm_pkg::ST_IDLE: begin
          if (turn_on && !rx_active) st_q <= rfm_pkg::ST_RUN;
        end
        rfm_pkg::ST_RUN: begin
          if (|ev) begin
            st_q <= rfm_pkg::ST_TRIP;
            src_q <= src_d;
            sev_q <= sev_d;
            latch_q <= |(latch_config & src_d); // R04
            prop_q <= |(spread_config & src_d); // R09 R15 R19
            recyc_q <= 1'b0;
          end else if (rx_valid) begin
            st_q <= rfm_pkg::ST_REMOTE;
            sev_q <= rfm_pkg::dec_sev(rx_sev); // R10
          end else if (!turn_on) begin
            st_q <= rfm_pkg::ST_IDLE;
          end
        end
        rfm_pkg::ST_TRIP: begin
          if (!turn_on) recyc_q <= 1'b1;
          if (tmr_done && turn_on) begin
            if (!latch_q) st_q <= rfm_pkg::ST_RUN; // R05
            else if (!(|(cond & src_q)) &&
                     (recyc_q || |(flags_q & src_q)))
              st_q <= rfm_pkg::ST_RUN; // R06
          end
        end
        rfm_pkg::ST_REMOTE: begin
          if (!rx_active)
            st_q <= turn_on ? rfm_pkg::ST_RUN : rfm_pkg::ST_IDLE; // R10
        end
        default: st_q <= rfm_pkg::ST_IDLE;
      endcase
    end
  end

  assign off = (st_q == rfm_pkg::ST_TRIP) || (st_q == rfm_pkg::ST_REMOTE);

  // switch control follows the turn-off severity
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hs_q <= 1'b0;
      ls_q <= 1'b0;
      force_q <= 1'b0;
      rdown_q <= 1'b0;
    end else begin
      hs_q <= (st_q == rfm_pkg::ST_RUN) ||
              (off && sev_q == rfm_pkg::SEV_SEQ); // R02 R07
      ls_q <= (st_q == rfm_pkg::ST_RUN) ||
              (off && sev_q != rfm_pkg::SEV_CRIT); // R07 R20
      force_q <= off && sev_q == rfm_pkg::SEV_EMERG; // R02 R07
      rdown_q <= off && sev_q == rfm_pkg::SEV_SEQ; // R07 R18
    end
  end

  // ramp request on each entry to run; sync fall as switching reference
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      was_run_q <= 1'b0;
      rup_q <= 1'b0;
      psync_q <= 1'b0;
    end else begin
      was_run_q <= st_q == rfm_pkg::ST_RUN;
      rup_q <= (st_q == rfm_pkg::ST_RUN) && !was_run_q; // R05
      psync_q <= sync_fall; // R21
    end
  end

  assign hs_en = hs_q;
  assign ls_en = ls_q;
  assign ls_force = force_q;
  assign ramp_down = rdown_q;
  assign ramp_up = rup_q;
  assign pwm_sync = psync_q;
  assign protection_flags = flags_q;
endmodule : rfm_regulator
`default_nettype wire

// file: rtl/rfm_manager.sv
// Purpose: power manager end: sync source, fault relay, status read
// Assumes: Avalon-MM slave with waitrequest, byte addresses
// Notes: relayed faults keep the severity they arrived with
`default_nettype none
module rfm_manager (
  input wire logic clk,
  input wire logic sys_rst,
  rfm_link_if.mgr link,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic xg_req,
  input wire logic [1:0] xg_sev,
  output logic grp_fault,
  output logic [1:0] grp_sev,
  output logic fe_off,
  output logic crowbar
);
  logic [3:0] ctrl_q, fl1_q, fl2_q, mflags_q;
  logic [4:0] div_q;
  logic sync_q, wait_q, flt_q, fe_q, crow_q;
  logic [1:0] sev_q;
  logic [31:0] rdata_q;
  logic rx_valid, rx_active, tx_drive_n;
  logic [1:0] rx_sev;
  logic xr1_q, xr2_q;
  logic [1:0] xs1_q, xs2_q;

  // relay request from another group crosses through two flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      xr1_q <= 1'b0;
      xr2_q <= 1'b0;
      xs1_q <= 2'h0;
      xs2_q <= 2'h0;
    end else begin
      xr1_q <= xg_req;
      xr2_q <= xr1_q;
      xs1_q <= xg_sev;
      xs2_q <= xs1_q;
    end
  end

  // sync line by division of the system clock
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_q <= '0;
      sync_q <= 1'b0;
    end else if (div_q == 5'(rfm_pkg::SYNC_HALF - 1)) begin
      div_q <= '0;
      sync_q <= ~sync_q;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end
  assign link.sync_line = sync_q;

  rfm_line_codec u_codec (
    .clk(clk),
    .sys_rst(sys_rst),
    .sync_in(sync_q),
    .line_in(link.fault_line),
    .tx_req(ctrl_q[rfm_pkg::C_RELAY] && xr2_q),
    .tx_sev(xs2_q), // R14
    .sync_fall(),
    .rx_valid(rx_valid),
    .rx_active(rx_active),
    .rx_sev(rx_sev),
    .tx_drive_n(tx_drive_n)
  );
  assign link.mgr_fault_o = 1'b0;
  assign link.mgr_fault_oe_n = tx_drive_n;

  // group fault state, relay and front-end actions
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flt_q <= 1'b0;
      sev_q <= 2'b00;
      fe_q <= 1'b0;
      crow_q <= 1'b0;
    end else begin
      flt_q <= rx_active;
      if (rx_valid) sev_q <= rx_sev; // R12 R14
      fe_q <= rx_active && ctrl_q[rfm_pkg::C_FE]; // R16
      crow_q <= rx_active && ctrl_q[rfm_pkg::C_CROW]; // R16
    end
  end

  // status path from the regulator crosses through two flip-flops
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      fl1_q <= rfm_pkg::FLAGS_RST;
      fl2_q <= rfm_pkg::FLAGS_RST;
      mflags_q <= rfm_pkg::FLAGS_RST;
    end else begin
      fl1_q <= link.flags;
      fl2_q <= fl1_q;
      if (ctrl_q[rfm_pkg::C_MON]) mflags_q <= fl2_q; // R08
    end
  end

  // avalon slave: one wait cycle, then the access completes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_q <= 1'b1;
      ctrl_q <= '0;
      rdata_q <= '0;
    end else begin
      wait_q <= !((avs_read || avs_write) && wait_q);
      if (avs_write && !wait_q && avs_address == rfm_pkg::REG_CTRL)
        ctrl_q <= avs_writedata[3:0];
      if (avs_read && wait_q) begin
        rdata_q <= '0;
        if (avs_address == rfm_pkg::REG_CTRL) rdata_q[3:0] <= ctrl_q;
        if (avs_address == rfm_pkg::REG_STAT) begin
          rdata_q[3:0] <= mflags_q;
          rdata_q[rfm_pkg::S_FLT] <= flt_q;
          rdata_q[rfm_pkg::S_SEV +: 2] <= sev_q;
          rdata_q[rfm_pkg::S_FE] <= fe_q;
          rdata_q[rfm_pkg::S_CROW] <= crow_q;
        end
      end
    end
  end

  assign avs_readdata = rdata_q;
  assign avs_waitrequest = wait_q;
  assign grp_fault = flt_q;
  assign grp_sev = sev_q;
  assign fe_off = fe_q;
  assign crowbar = crow_q;
endmodule : rfm_manager
`default_nettype wire

// file: testbench/rfm_link_monitor.sv
// Purpose: watches sync line, fault line drivers and flags on the link
// Assumes: sync half period of rfm_pkg::SYNC_HALF clocks
// Notes: instantiated by the bench beside the link interface
`default_nettype none
module rfm_link_monitor (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sync_line,
  input wire logic dev_fault_o,
  input wire logic dev_fault_oe_n,
  input wire logic mgr_fault_o,
  input wire logic mgr_fault_oe_n,
  input wire logic fault_line,
  input wire logic [3:0] flags
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic [7:0] sc_q;
  logic seen_q;
  logic prev_q;
  // cycles since the last sync line change
  always_ff @(posedge clk) begin
    prev_q <= sync_line;
    if (sys_rst || sync_line != prev_q) sc_q <= 8'h00;
    else sc_q <= sc_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) seen_q <= 1'b0;
    else if (sync_line != prev_q) seen_q <= 1'b1;
  end
  AST_SYNC_HALF:
    assert property (seen_q && sync_line != prev_q |->
      sc_q == 8'(rfm_pkg::SYNC_HALF - 1)) else $error("sync half wrong");
  AST_SYNC_RUNS:
    assert property (seen_q |-> sc_q < 8'(rfm_pkg::SYNC_HALF))
    else $error("sync line stalled");
  AST_DEV_OPEN_DRAIN:
    assert property (!dev_fault_oe_n |-> !dev_fault_o)
    else $error("device drives fault line high");
  AST_MGR_OPEN_DRAIN:
    assert property (!mgr_fault_oe_n |-> !mgr_fault_o)
    else $error("manager drives fault line high");
  AST_DEV_PULL_ALIGN:
    assert property ($fell(dev_fault_oe_n) |-> !sync_line && sc_q < 8'd10)
    else $error("device pull not at sync fall");
  AST_MGR_PULL_ALIGN:
    assert property ($fell(mgr_fault_oe_n) |-> !sync_line && sc_q < 8'd10)
    else $error("manager pull not at sync fall");
  AST_DEV_START_HOLD:
    assert property ($fell(dev_fault_oe_n) |-> !dev_fault_oe_n[*8])
    else $error("start period cut short");
  AST_DEV_NEEDS_TRIP:
    assert property ($fell(dev_fault_oe_n) |-> flags != 4'hf)
    else $error("device pulls line with no fault flagged");
  cover property ($fell(dev_fault_oe_n));
  cover property ($fell(mgr_fault_oe_n));
  cover property ($fell(fault_line) ##[1:200] $rose(fault_line));
endmodule : rfm_link_monitor
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: drives regulator and manager facing each other on the link
// Assumes: restart interval shortened to RST_CYC clocks
// Notes: manager registers reached over Avalon-MM with waitrequest
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RST_CYC = 2000;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic turn_on = 1'b1, above_prebias = 1'b1, steady_state = 1'b1;
  logic oc_in = 1'b0, uv_in = 1'b0, xg_req = 1'b0;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [12:0] vout_mv = 13'h3e8, setpoint_mv = 13'h3e8;
  logic [7:0] ov_pct = 8'h78, temp_c = 8'h19;
  logic [3:0] latch_config = 4'h0, spread_config = 4'hf;
  logic [3:0] status_clear = 4'h0, avs_address = 4'h0;
  logic [1:0] style_ot = 2'h0, style_uv = 2'h0, style_ov = 2'h3;
  logic [1:0] xg_sev = 2'h0, grp_sev;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic hs_en, ls_en, ls_force, ramp_down, ramp_up, pwm_sync;
  logic fe_off, crowbar;
  logic avs_waitrequest, grp_fault;
  logic [3:0] protection_flags;
  int miscompares = 0, samples_checked = 0, cycles = 0;
  rfm_link_if lnk ();
  rfm_regulator #(.RESTART_CYC(RST_CYC)) i_rfm_regulator (.clk, .sys_rst,
    .link(lnk), .turn_on, .above_prebias, .steady_state, .oc_in, .uv_in,
    .vout_mv, .setpoint_mv, .ov_pct, .temp_c, .latch_config,
    .spread_config, .status_clear, .style_ot, .style_uv, .style_ov,
    .hs_en, .ls_en, .ls_force, .ramp_down, .ramp_up, .pwm_sync,
    .protection_flags);
  rfm_manager i_rfm_manager (.clk, .sys_rst, .link(lnk), .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .xg_req, .xg_sev, .grp_fault, .grp_sev, .fe_off,
    .crowbar);
  rfm_link_monitor i_rfm_link_monitor (.clk, .sys_rst,
    .sync_line(lnk.sync_line), .dev_fault_o(lnk.dev_fault_o),
    .dev_fault_oe_n(lnk.dev_fault_oe_n), .mgr_fault_o(lnk.mgr_fault_o),
    .mgr_fault_oe_n(lnk.mgr_fault_oe_n), .fault_line(lnk.fault_line),
    .flags(lnk.flags));
  initial forever #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // bounded wait for a level, sampled at rising edges
  task automatic wt(input string nm, ref logic s, input logic v,
                    input int lim);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge clk);
      n++;
    end
    chk(nm, n < lim, 1'b1);
  endtask : wt
  task automatic bus(input logic wr, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    chk("bus answer", n < 20, 1'b1);
  endtask : bus
  task automatic clr(input logic [3:0] b);
    status_clear <= b;
    @(posedge clk);
    status_clear <= 4'h0;
    repeat (3) @(posedge clk);
    chk("flags cleared", protection_flags, 4'hf);
  endtask : clr
  task automatic t_regs;
    logic [31:0] q;
    int n;
    bus(1'b1, rfm_pkg::REG_CTRL, 32'h0000000f, q);
    bus(1'b0, rfm_pkg::REG_CTRL, 32'h00000000, q);
    chk("ctrl", q, 32'h0000000f);
    bus(1'b1, rfm_pkg::REG_STAT, 32'h000001f0, q);
    bus(1'b0, 4'h8, 32'h00000000, q);
    chk("unmapped", q, 32'h00000000);
    repeat (4) @(posedge clk);
    bus(1'b0, rfm_pkg::REG_STAT, 32'h00000000, q);
    chk("status idle", q, 32'h0000000f);
    n = 0;
    repeat (200) begin
      @(posedge clk);
      if (pwm_sync === 1'b1) n++;
    end
    chk("sync pulses", n, 4);
    $display("test regs done");
  endtask : t_regs
  task automatic t_ov;
    logic [31:0] q;
    int t;
    vout_mv <= 13'h4e2;
    repeat (20) @(posedge clk);
    chk("ov at limit", protection_flags, 4'hf);
    vout_mv <= 13'h4e3;
    wt("ov trip", hs_en, 1'b0, 10);
    t = cycles;
    chk("ov sw", {ls_en, ls_force, protection_flags}, 6'h3e);
    wt("ov line", grp_fault, 1'b1, 400);
    chk("ov sev", grp_sev, 2'h3);
    repeat (8) @(posedge clk);
    bus(1'b0, rfm_pkg::REG_STAT, 32'h00000000, q);
    chk("ov status", q, 32'h000001fe);
    chk("ov front end", {fe_off, crowbar}, 2'h3);
    vout_mv <= 13'h3e8;
    wt("ov restart", ramp_up, 1'b1, 2100);
    t = cycles - t;
    chk("ov gap", t >= RST_CYC - 10 && t <= RST_CYC + 10, 1'b1);
    clr(4'h1);
    chk("ov line free", lnk.fault_line, 1'b1);
    $display("test ov done");
  endtask : t_ov
  task automatic t_uv;
    int n;
    spread_config <= 4'h0;
    uv_in <= 1'b1;
    wt("uv trip", ramp_down, 1'b1, 10);
    chk("uv sw", {hs_en, protection_flags}, 5'h1d);
    n = 0;
    repeat (300) begin
      @(posedge clk);
      if (lnk.fault_line !== 1'b1) n++;
    end
    chk("uv line", n, 0);
    chk("uv group", grp_fault, 1'b0);
    uv_in <= 1'b0;
    wt("uv restart", ramp_up, 1'b1, 2100);
    clr(4'h2);
    spread_config <= 4'hf;
    $display("test uv done");
  endtask : t_uv
  task automatic t_oc;
    int n;
    latch_config <= 4'h8;
    oc_in <= 1'b1;
    wt("oc trip", hs_en, 1'b0, 10);
    chk("oc sw", {ls_en, ls_force, protection_flags}, 6'h07);
    wt("oc line", grp_fault, 1'b1, 400);
    chk("oc sev", grp_sev, 2'h1);
    oc_in <= 1'b0;
    n = 0;
    repeat (2300) begin
      @(posedge clk);
      if (ramp_up === 1'b1) n++;
    end
    chk("latched", n, 0);
    clr(4'h8);
    wt("latch restart", ramp_up, 1'b1, 50);
    oc_in <= 1'b1;
    wt("oc again", hs_en, 1'b0, 10);
    oc_in <= 1'b0;
    turn_on <= 1'b0;
    repeat (2100) @(posedge clk);
    chk("off while low", {hs_en, ramp_up, protection_flags}, 6'h07);
    turn_on <= 1'b1;
    wt("recycle restart", ramp_up, 1'b1, 10);
    clr(4'h8);
    wt("oc line free", grp_fault, 1'b0, 200);
    latch_config <= 4'h0;
    $display("test oc done");
  endtask : t_oc
  task automatic t_remote;
    logic [1:0] sv [3] = '{2'h0, 2'h1, 2'h3};
    logic [3:0] ex [3] = '{4'hd, 4'h0, 4'h6};
    for (int i = 0; i < 3; i++) begin
      xg_sev <= sv[i];
      xg_req <= 1'b1;
      wt("relay", grp_fault, 1'b1, 400);
      chk("relay sev", grp_sev, sv[i]);
      repeat (20) @(posedge clk);
      chk("remote off", {hs_en, ls_en, ls_force, ramp_down}, ex[i]);
      chk("remote flags", protection_flags, 4'hf);
      xg_req <= 1'b0;
      wt("remote on", ramp_up, 1'b1, 300);
      repeat (10) @(posedge clk);
    end
    $display("test remote done");
  endtask : t_remote
  task automatic t_ot;
    temp_c <= 8'h82;
    repeat (20) @(posedge clk);
    chk("ot at limit", protection_flags, 4'hf);
    temp_c <= 8'h83;
    wt("ot trip", ramp_down, 1'b1, 10);
    chk("ot flag", protection_flags, 4'hb);
    temp_c <= 8'h19;
    wt("ot restart", ramp_up, 1'b1, 2100);
    clr(4'h4);
    $display("test ot done");
  endtask : t_ot
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_regs();
    t_ov();
    t_uv();
    t_oc();
    t_remote();
    t_ot();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
